// >>> iafcu_consts.svh
// constant definitions for the in-application flash command unit
`ifndef IAFCU_CONSTS_SVH
`define IAFCU_CONSTS_SVH

`define IAFCU_REGION_APP     2'h0
`define IAFCU_REGION_LOADER  2'h1
`define IAFCU_REGION_CONFIG  2'h3
`define IAFCU_REGION_RESERVED 2'h2

`define IAFCU_FUNC_READ      4'h0
`define IAFCU_FUNC_PROGRAM   4'h1
`define IAFCU_FUNC_ERASE     4'h2
`define IAFCU_FUNC_UID       4'h4
`define IAFCU_FUNC_MAKER     4'hB
`define IAFCU_FUNC_DEVICE    4'hC

`define IAFCU_TA_KEY_FIRST   8'hAA
`define IAFCU_TA_KEY_SECOND  8'h55
`define IAFCU_TA_WINDOW      3'h4

`define IAFCU_ERASED_BYTE    8'hFF
`define IAFCU_PAGE_LAST      8'hFF
`define IAFCU_CFG_LAST       8'h07
`define IAFCU_COUNT_RESET    8'h00
`define IAFCU_DATA_RESET     8'h00
`define IAFCU_ADDR_ZERO      16'h0000
`define IAFCU_ADDR_ONE       16'h0001
`define IAFCU_CFG_ADDR_TWO   16'h0002
`define IAFCU_CFG_ADDR_FOUR  16'h0004
`define IAFCU_UID_LAST       16'h000B
`define IAFCU_PAGE_MASK      16'hFF00

`endif

// >>> iafcu_pkg.sv
// types shared by the in-application flash command unit
package iafcu_pkg;

  typedef struct packed {
    logic [1:0] regionSelect;
    logic       writeOpEnable;
    logic       secondOpEnable;
    logic [3:0] functionCode;
  } iafcu_ctrl_type;

  typedef struct packed {
    logic configUpdateEnable;
    logic loaderUpdateEnable;
    logic applicationUpdateEnable;
  } iafcu_upd_type;

  typedef enum logic [1:0] {
    IAFCU_IDLE   = 2'h0,
    IAFCU_ACCESS = 2'h1,
    IAFCU_ERASE  = 2'h3,
    IAFCU_FINISH = 2'h2
  } iafcu_state_type;

endpackage

// >>> iafcu_mem.sv
// flash array model: one port, byte write, registered read
`timescale 1ns/1ps
module iafcu_mem #(
  parameter int DEPTH = 1024,
  parameter int AW    = 10
) (
  // clock
  input  wire logic          core_clk,
  // access port
  input  wire logic          writeEn,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    writeData,
  output logic      [7:0]    readData
);

  logic [7:0] memArray [DEPTH];

  always_ff @(posedge core_clk) begin
    if (writeEn) begin
      memArray[addr] <= writeData;
    end
    readData <= memArray[addr];
  end

endmodule

// >>> iafcu_unlock.sv
// timed-access unlock: key pair opens a short write window
`timescale 1ns/1ps
`include "iafcu_consts.svh"
module iafcu_unlock (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rstn,
  // key writes
  input  wire logic       keyWrite,
  input  wire logic [7:0] keyData,
  // protected write taken
  input  wire logic       consume,
  // window open
  output logic            unlocked
);

  logic       armed_reg;
  logic       armed_next;
  logic [2:0] window_reg;
  logic [2:0] window_next;

  always_comb begin
    armed_next  = armed_reg;
    window_next = window_reg;
    if (window_reg != 3'h0) begin
      window_next = window_reg - 3'h1;
    end
    if (consume) begin
      window_next = 3'h0;
    end
    if (keyWrite) begin
      armed_next = (keyData == `IAFCU_TA_KEY_FIRST);
      if (armed_reg && keyData == `IAFCU_TA_KEY_SECOND) begin
        window_next = `IAFCU_TA_WINDOW;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      armed_reg  <= 1'b0;
      window_reg <= 3'h0;
    end else begin
      armed_reg  <= armed_next;
      window_reg <= window_next;
    end
  end

  assign unlocked = (window_reg != 3'h0);

endmodule

// >>> iafcu_core.sv
// in-application flash command decode and sequencing
// Summary of operation
// - operation taken from control value at trigger
// - region 00 application, 01 loader, 11 config
// - function 0/1/2 read/program/erase, enables checked
// - 1011 maker code, 1100 device code bytes
// - 0100 returns unique identifier byte 0 to 11
// - page erase clears addressed 256-byte page
// - config erase clears all config bytes
// - config bytes at addresses 0,1,2,4
// - trigger ignored while command enable clear
// - RC oscillator runs while enabled or internal
// - enable write only after unlock sequence
// - lock bit never blocks flash commands
// - code-read path reads application region bytes only
// - processor held until done, trigger reads zero
// - erase/program refused without region update enable
// - sticky failure flag on invalid or refused
`timescale 1ns/1ps
`include "iafcu_consts.svh"
module iafcu_core
  import iafcu_pkg::*;
#(
  parameter int          APP_AW      = 14,
  parameter int          LOADER_AW   = 12,
  parameter int          CFG_AW      = 3,
  parameter logic [7:0]  MAKER_CODE  = 8'hA5,   // arbitrary value
  parameter logic [15:0] DEVICE_CODE = 16'h1234, // arbitrary value
  parameter logic [95:0] UNIQUE_ID   = 96'h0123_4567_89AB_CDEF_0011_2233
) (
  // clock and reset
  input  wire logic          core_clk,
  input  wire logic          rstn,
  // command set-up
  input  iafcu_ctrl_type     flashCmdControl,
  input  wire logic [15:0]   flashTargetAddress,
  input  wire logic          dataWrite,
  input  wire logic [7:0]    dataWriteValue,
  // protected writes
  input  wire logic          taWrite,
  input  wire logic [7:0]    taData,
  input  wire logic          triggerWrite,
  input  wire logic          triggerValue,
  input  wire logic          enableWrite,
  input  wire logic          enableValue,
  input  wire logic          updateWrite,
  input  iafcu_upd_type      updateValue,
  input  wire logic          failClear,
  // clocking
  input  wire logic          extClockSelect,
  output logic               rcOscRun,
  // status
  output logic [7:0]         flashDataByte,
  output logic               flashCmdEnable,
  output iafcu_upd_type      regionUpdateEnables,
  output logic               failFlag,
  output logic               cpuHold,
  output logic               unlockOpen,
  // code-memory read
  input  wire logic          codeReadReq,
  input  wire logic [15:0]   codeReadAddr,
  output logic [7:0]         codeReadData,
  output logic               codeReadValid
);

  localparam int APP_DEPTH = 1 << APP_AW;
  localparam int LD_DEPTH  = 1 << LOADER_AW;
  localparam int CFG_DEPTH = 1 << CFG_AW;
  localparam int MEM_DEPTH = APP_DEPTH + LD_DEPTH + CFG_DEPTH;
  localparam int MAW       = $clog2(MEM_DEPTH);
  localparam logic [MAW-1:0] LD_BASE  = MAW'(APP_DEPTH);
  localparam logic [MAW-1:0] CFG_BASE = MAW'(APP_DEPTH + LD_DEPTH);

  // byte address in flash array for a region and offset
  function automatic logic [MAW-1:0] memIndex(input logic [1:0]  region,
                                             input logic [15:0] addr);
    logic [MAW-1:0] idx;
    idx = '0;
    case (region)
      `IAFCU_REGION_APP:    idx = MAW'(addr[APP_AW-1:0]);
      `IAFCU_REGION_LOADER: idx = LD_BASE + MAW'(addr[LOADER_AW-1:0]);
      `IAFCU_REGION_CONFIG: idx = CFG_BASE + MAW'(addr[CFG_AW-1:0]);
      default:              idx = '0;
    endcase
    return idx;
  endfunction

  // region has its update enable set
  function automatic logic regionWritable(input logic [1:0]    region,
                                          input iafcu_upd_type upd);
    logic ok;
    ok = 1'b0;
    case (region)
      `IAFCU_REGION_APP:    ok = upd.applicationUpdateEnable;
      `IAFCU_REGION_LOADER: ok = upd.loaderUpdateEnable;
      `IAFCU_REGION_CONFIG: ok = upd.configUpdateEnable;
      default:              ok = 1'b0;
    endcase
    return ok;
  endfunction

  iafcu_state_type state_reg;
  iafcu_state_type state_next;
  iafcu_ctrl_type  cmd_reg;
  iafcu_ctrl_type  cmd_next;
  iafcu_upd_type   upd_reg;
  iafcu_upd_type   upd_next;
  logic [15:0]     addr_reg;
  logic [15:0]     addr_next;
  logic [7:0]      data_reg;
  logic [7:0]      data_next;
  logic [7:0]      count_reg;
  logic [7:0]      count_next;
  logic            enable_reg;
  logic            enable_next;
  logic            fail_reg;
  logic            fail_next;
  logic            capture_reg;
  logic            capture_next;
  logic            codeValid_reg;
  logic            codeValid_next;

  logic            unlocked;
  logic            protectedTaken;
  logic            go;
  logic            memWe;
  logic [MAW-1:0]  memAddr;
  logic [7:0]      memWdata;
  logic [7:0]      memRdata;
  logic [7:0]      eraseLast;
  logic            cfgAddrOk;
  logic            isConfig;
  logic [95:0]     uidShift;

  iafcu_unlock u_unlock (
    .core_clk (core_clk),
    .rstn     (rstn),
    .keyWrite (taWrite),
    .keyData  (taData),
    .consume  (protectedTaken),
    .unlocked (unlocked)
  );

  iafcu_mem #(
    .DEPTH (MEM_DEPTH),
    .AW    (MAW)
  ) u_mem (
    .core_clk  (core_clk),
    .writeEn   (memWe),
    .addr      (memAddr),
    .writeData (memWdata),
    .readData  (memRdata)
  );

  assign protectedTaken = unlocked & (triggerWrite | enableWrite | updateWrite);
  assign go = triggerWrite & triggerValue & unlocked & enable_reg
              & (state_reg == IAFCU_IDLE);
  assign isConfig  = (cmd_reg.regionSelect == `IAFCU_REGION_CONFIG);
  assign cfgAddrOk = (addr_reg == `IAFCU_ADDR_ZERO) || (addr_reg == `IAFCU_ADDR_ONE)
                     || (addr_reg == `IAFCU_CFG_ADDR_TWO)
                     || (addr_reg == `IAFCU_CFG_ADDR_FOUR);
  assign eraseLast = isConfig ? `IAFCU_CFG_LAST : `IAFCU_PAGE_LAST;
  assign uidShift  = UNIQUE_ID >> {addr_reg[3:0], 3'h0};

  // enable and update-enable writes
  always_comb begin
    enable_next = enable_reg;
    upd_next    = upd_reg;
    if (enableWrite && unlocked) begin
      enable_next = enableValue;
    end
    if (updateWrite && unlocked) begin
      upd_next = updateValue;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      enable_reg <= 1'b0;
      upd_reg    <= '0;
    end else begin
      enable_reg <= enable_next;
      upd_reg    <= upd_next;
    end
  end

  // command sequencer; lock bit is deliberately not an input here
  always_comb begin
    state_next     = state_reg;
    cmd_next       = cmd_reg;
    addr_next      = addr_reg;
    data_next      = data_reg;
    count_next     = count_reg;
    fail_next      = fail_reg;
    capture_next   = 1'b0;
    codeValid_next = 1'b0;
    memWe          = 1'b0;
    memWdata       = data_reg;
    memAddr        = MAW'(codeReadAddr[APP_AW-1:0]);
    if (failClear) begin
      fail_next = 1'b0;
    end
    if (dataWrite && state_reg == IAFCU_IDLE) begin
      data_next = dataWriteValue;
    end
    case (state_reg)
      IAFCU_IDLE: begin
        codeValid_next = codeReadReq;
        if (go) begin
          cmd_next   = flashCmdControl;
          addr_next  = flashTargetAddress;
          count_next = `IAFCU_COUNT_RESET;
          state_next = IAFCU_ACCESS;
        end
      end
      IAFCU_ACCESS: begin
        state_next = IAFCU_FINISH;
        memAddr    = memIndex(cmd_reg.regionSelect, addr_reg);
        if (cmd_reg.secondOpEnable) begin
          fail_next = 1'b1;
        end else begin
          case (cmd_reg.functionCode)
            `IAFCU_FUNC_MAKER: begin
              if (cmd_reg.writeOpEnable) fail_next = 1'b1;
              else data_next = MAKER_CODE;
            end
            `IAFCU_FUNC_DEVICE: begin
              if (cmd_reg.writeOpEnable) fail_next = 1'b1;
              else if (addr_reg == `IAFCU_ADDR_ZERO) data_next = DEVICE_CODE[7:0];
              else if (addr_reg == `IAFCU_ADDR_ONE) data_next = DEVICE_CODE[15:8];
              else data_next = `IAFCU_ERASED_BYTE;
            end
            `IAFCU_FUNC_UID: begin
              if (cmd_reg.writeOpEnable) fail_next = 1'b1;
              else if (addr_reg <= `IAFCU_UID_LAST) data_next = uidShift[7:0];
              else data_next = `IAFCU_ERASED_BYTE;
            end
            `IAFCU_FUNC_READ: begin
              if (cmd_reg.writeOpEnable
                  || cmd_reg.regionSelect == `IAFCU_REGION_RESERVED
                  || (isConfig && !cfgAddrOk)) begin
                fail_next = 1'b1;
              end else begin
                capture_next = 1'b1;
              end
            end
            `IAFCU_FUNC_PROGRAM: begin
              if (!cmd_reg.writeOpEnable
                  || !regionWritable(cmd_reg.regionSelect, upd_reg)
                  || (isConfig && !cfgAddrOk)) begin
                fail_next = 1'b1;
              end else begin
                memWe = 1'b1;
              end
            end
            `IAFCU_FUNC_ERASE: begin
              if (!cmd_reg.writeOpEnable
                  || !regionWritable(cmd_reg.regionSelect, upd_reg)
                  || (isConfig && addr_reg != `IAFCU_ADDR_ZERO)) begin
                fail_next = 1'b1;
              end else begin
                state_next = IAFCU_ERASE;
              end
            end
            default: fail_next = 1'b1;
          endcase
        end
      end
      IAFCU_ERASE: begin
        memWe      = 1'b1;
        memWdata   = `IAFCU_ERASED_BYTE;
        memAddr    = memIndex(cmd_reg.regionSelect,
                              (addr_reg & `IAFCU_PAGE_MASK) | {8'h00, count_reg});
        count_next = count_reg + 8'h01;
        if (count_reg == eraseLast) begin
          state_next = IAFCU_FINISH;
        end
      end
      IAFCU_FINISH: begin
        if (capture_reg) begin
          data_next = memRdata;
        end
        state_next = IAFCU_IDLE;
      end
      default: state_next = IAFCU_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg     <= IAFCU_IDLE;
      cmd_reg       <= '0;
      addr_reg      <= `IAFCU_ADDR_ZERO;
      data_reg      <= `IAFCU_DATA_RESET;
      count_reg     <= `IAFCU_COUNT_RESET;
      fail_reg      <= 1'b0;
      capture_reg   <= 1'b0;
      codeValid_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      cmd_reg       <= cmd_next;
      addr_reg      <= addr_next;
      data_reg      <= data_next;
      count_reg     <= count_next;
      fail_reg      <= fail_next;
      capture_reg   <= capture_next;
      codeValid_reg <= codeValid_next;
    end
  end

  // trigger is a strobe only, nothing stored to read back
  assign cpuHold             = (state_reg != IAFCU_IDLE);
  assign rcOscRun            = enable_reg | ~extClockSelect;
  assign flashDataByte       = data_reg;
  assign flashCmdEnable      = enable_reg;
  assign regionUpdateEnables = upd_reg;
  assign failFlag            = fail_reg;
  assign unlockOpen          = unlocked;
  assign codeReadData        = memRdata;
  assign codeReadValid       = codeValid_reg;

endmodule

// >>> iafcu_core_monitor.sv
// concurrent checks on the flash command unit ports
`timescale 1ns/1ps
module iafcu_core_monitor
  import iafcu_pkg::*;
(
  // clock and reset
  input wire logic       core_clk,
  input wire logic       rstn,
  // watched inputs
  input iafcu_ctrl_type  flashCmdControl,
  input wire logic       taWrite,
  input wire logic [7:0] taData,
  input wire logic       triggerWrite,
  input wire logic       triggerValue,
  input wire logic       enableWrite,
  input wire logic       updateWrite,
  input wire logic       failClear,
  input wire logic       extClockSelect,
  input wire logic       codeReadReq,
  // watched outputs
  input wire logic       rcOscRun,
  input wire logic       flashCmdEnable,
  input iafcu_upd_type   regionUpdateEnables,
  input wire logic       failFlag,
  input wire logic       cpuHold,
  input wire logic       unlockOpen,
  input wire logic       codeReadValid
);
  logic go;
  assign go = triggerWrite && triggerValue && unlockOpen && flashCmdEnable && !cpuHold;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  property p_osc_follow;
    rcOscRun == (flashCmdEnable || !extClockSelect);
  endproperty
  a_osc_follow: assert property (p_osc_follow) else $error("osc run mismatch");
  property p_hold_start;
    go |=> cpuHold;
  endproperty
  a_hold_start: assert property (p_hold_start) else $error("hold missing");
  property p_hold_short;
    go && flashCmdControl.functionCode != 4'h2 |=> cpuHold [*2] ##1 !cpuHold;
  endproperty
  a_hold_short: assert property (p_hold_short) else $error("hold length wrong");
  property p_trig_ignored;
    triggerWrite && triggerValue && !flashCmdEnable && !cpuHold |=> !cpuHold;
  endproperty
  a_trig_ignored: assert property (p_trig_ignored) else $error("trigger not ignored");
  property p_unlock_open;
    taWrite && taData == 8'h55 && $past(taWrite) && $past(taData) == 8'hAA |=> unlockOpen;
  endproperty
  a_unlock_open: assert property (p_unlock_open) else $error("window not open");
  property p_enable_locked;
    enableWrite && !unlockOpen |=> $stable(flashCmdEnable);
  endproperty
  a_enable_locked: assert property (p_enable_locked) else $error("enable changed");
  property p_update_locked;
    updateWrite && !unlockOpen |=> $stable(regionUpdateEnables);
  endproperty
  a_update_locked: assert property (p_update_locked) else $error("update changed");
  property p_second_fails;
    go && flashCmdControl.secondOpEnable |-> ##[1:3] failFlag;
  endproperty
  a_second_fails: assert property (p_second_fails) else $error("no fail flag");
  property p_fail_sticky;
    failFlag && !failClear |=> failFlag;
  endproperty
  a_fail_sticky: assert property (p_fail_sticky) else $error("fail flag dropped");
  property p_code_read;
    codeReadReq && !cpuHold |=> codeReadValid;
  endproperty
  a_code_read: assert property (p_code_read) else $error("code read lost");
endmodule

bind iafcu_core iafcu_core_monitor mon_u (
  .core_clk(core_clk), .rstn(rstn), .flashCmdControl(flashCmdControl),
  .taWrite(taWrite), .taData(taData), .triggerWrite(triggerWrite),
  .triggerValue(triggerValue), .enableWrite(enableWrite), .updateWrite(updateWrite),
  .failClear(failClear), .extClockSelect(extClockSelect), .codeReadReq(codeReadReq),
  .rcOscRun(rcOscRun), .flashCmdEnable(flashCmdEnable),
  .regionUpdateEnables(regionUpdateEnables), .failFlag(failFlag), .cpuHold(cpuHold),
  .unlockOpen(unlockOpen), .codeReadValid(codeReadValid)
);

// >>> tb_top.sv
// self-checking bench for the flash command unit
`timescale 1ns/1ps
module tb_top;
  import iafcu_pkg::*;
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [15:0] addr;
    logic [7:0]  din;
    logic [7:0]  dout;
    logic        chkD;
    logic        fail;
  } iafcu_row_type;
  logic           core_clk, rstn, dataWrite, taWrite, triggerWrite, triggerValue;
  logic           enableWrite, enableValue, updateWrite, failClear, extClockSelect;
  logic           rcOscRun, flashCmdEnable, failFlag, cpuHold, unlockOpen;
  logic           codeReadReq, codeReadValid;
  logic [7:0]     dataWriteValue, taData, flashDataByte, codeReadData;
  logic [15:0]    flashTargetAddress, codeReadAddr, hl;
  iafcu_ctrl_type flashCmdControl;
  iafcu_upd_type  updateValue, regionUpdateEnables;
  int             n_mismatch, checks;
  iafcu_row_type  rows [0:26] = '{
    '{8'h0B, 16'h1234, 8'h00, 8'hA5, 1'b1, 1'b0},
    '{8'h0C, 16'h0000, 8'h00, 8'h34, 1'b1, 1'b0},
    '{8'h0C, 16'h0001, 8'h00, 8'h12, 1'b1, 1'b0},
    '{8'h0C, 16'h0002, 8'h00, 8'hFF, 1'b1, 1'b0},
    '{8'hC4, 16'h0000, 8'h00, 8'h33, 1'b1, 1'b0},
    '{8'h04, 16'h000B, 8'h00, 8'h01, 1'b1, 1'b0},
    '{8'h04, 16'h000C, 8'h00, 8'hFF, 1'b1, 1'b0},
    '{8'h22, 16'h0200, 8'hFF, 8'h00, 1'b0, 1'b0},
    '{8'h21, 16'h0201, 8'h55, 8'h00, 1'b0, 1'b0},
    '{8'h00, 16'h0201, 8'h00, 8'h55, 1'b1, 1'b0},
    '{8'h00, 16'h0200, 8'h00, 8'hFF, 1'b1, 1'b0},
    '{8'h00, 16'h02FF, 8'h00, 8'hFF, 1'b1, 1'b0},
    '{8'h62, 16'h0100, 8'hFF, 8'h00, 1'b0, 1'b0},
    '{8'h61, 16'h0105, 8'hA7, 8'h00, 1'b0, 1'b0},
    '{8'h40, 16'h0105, 8'h00, 8'hA7, 1'b1, 1'b0},
    '{8'hE2, 16'h0000, 8'hFF, 8'h00, 1'b0, 1'b0},
    '{8'hC0, 16'h0002, 8'h00, 8'hFF, 1'b1, 1'b0},
    '{8'hE1, 16'h0004, 8'h3C, 8'h00, 1'b0, 1'b0},
    '{8'hC0, 16'h0004, 8'h00, 8'h3C, 1'b1, 1'b0},
    '{8'hC0, 16'h0003, 8'h00, 8'h00, 1'b0, 1'b1},
    '{8'h10, 16'h0201, 8'h00, 8'h00, 1'b0, 1'b1},
    '{8'h01, 16'h0201, 8'h00, 8'h00, 1'b0, 1'b1},
    '{8'h80, 16'h0201, 8'h00, 8'h00, 1'b0, 1'b1},
    '{8'h07, 16'h0201, 8'h00, 8'h00, 1'b0, 1'b1},
    '{8'h20, 16'h0201, 8'h00, 8'h00, 1'b0, 1'b1},
    '{8'h00, 16'h0201, 8'h00, 8'h55, 1'b1, 1'b0},
    '{8'hE2, 16'h0001, 8'hFF, 8'h00, 1'b0, 1'b1}
  };

  iafcu_core dut_u (
    .core_clk(core_clk), .rstn(rstn), .flashCmdControl(flashCmdControl),
    .flashTargetAddress(flashTargetAddress), .dataWrite(dataWrite),
    .dataWriteValue(dataWriteValue), .taWrite(taWrite), .taData(taData),
    .triggerWrite(triggerWrite), .triggerValue(triggerValue), .enableWrite(enableWrite),
    .enableValue(enableValue), .updateWrite(updateWrite), .updateValue(updateValue),
    .failClear(failClear), .extClockSelect(extClockSelect), .rcOscRun(rcOscRun),
    .flashDataByte(flashDataByte), .flashCmdEnable(flashCmdEnable),
    .regionUpdateEnables(regionUpdateEnables), .failFlag(failFlag), .cpuHold(cpuHold),
    .unlockOpen(unlockOpen), .codeReadReq(codeReadReq), .codeReadAddr(codeReadAddr),
    .codeReadData(codeReadData), .codeReadValid(codeReadValid)
  );

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // key pair; window is open at the negedge this returns on
  task automatic unlock();
    @(negedge core_clk);
    taWrite = 1'b1;
    taData = 8'hAA;
    @(negedge core_clk);
    taData = 8'h55;
    @(negedge core_clk);
    taWrite = 1'b0;
  endtask

  task automatic protWrite(input logic isEn, input logic [2:0] v);
    unlock();
    chk("unlockOpen", unlockOpen, 16'h0001);
    enableWrite = isEn;
    updateWrite = !isEn;
    enableValue = v[0];
    updateValue = v;
    @(negedge core_clk);
    enableWrite = 1'b0;
    updateWrite = 1'b0;
    chk("unlockClosed", unlockOpen, 16'h0000);
  endtask

  function automatic logic [15:0] expHold(input logic [7:0] c);
    if (c[3:0] != 4'h2) return 16'h0002;
    return (c[7:6] == 2'h3) ? 16'h000A : 16'h0102;
  endfunction

  task automatic runOp(input iafcu_row_type r, input int gap, output logic [15:0] n);
    n = 16'h0000;
    flashCmdControl = r.ctrl;
    flashTargetAddress = r.addr;
    dataWriteValue = r.din;
    dataWrite = 1'b1;
    failClear = 1'b1;
    @(negedge core_clk);
    dataWrite = 1'b0;
    failClear = 1'b0;
    unlock();
    repeat (gap) @(negedge core_clk);
    triggerWrite = 1'b1;
    triggerValue = 1'b1;
    @(negedge core_clk);
    triggerWrite = 1'b0;
    while (cpuHold === 1'b1 && n < 16'h0200) begin
      n++;
      @(negedge core_clk);
    end
  endtask

  task automatic codeRead(input logic [15:0] a, input logic [7:0] exp);
    @(negedge core_clk);
    codeReadReq = 1'b1;
    codeReadAddr = a;
    @(negedge core_clk);
    codeReadReq = 1'b0;
    chk("codeReadValid", codeReadValid, 16'h0001);
    chk("codeReadData", codeReadData, exp);
  endtask

  initial begin
    #1000000;
    n_mismatch++;
    summarize();
  end

  initial begin
    {dataWrite, taWrite, triggerWrite, triggerValue, enableWrite, enableValue} = 6'h00;
    {updateWrite, failClear, codeReadReq, taData, dataWriteValue} = 19'h00000;
    {flashCmdControl, flashTargetAddress, codeReadAddr, updateValue} = 43'h0;
    extClockSelect = 1'b1;
    n_mismatch = 0;
    checks = 0;
    rstn = 1'b0;
    repeat (4) @(negedge core_clk);
    rstn = 1'b1;
    chk("resetState", {flashDataByte, flashCmdEnable, regionUpdateEnables, failFlag, cpuHold,
        unlockOpen, rcOscRun}, 16'h0000);
    enableWrite = 1'b1;
    updateWrite = 1'b1;
    enableValue = 1'b1;
    updateValue = 3'h7;
    @(negedge core_clk);
    enableWrite = 1'b0;
    updateWrite = 1'b0;
    chk("lockedWrites", {flashCmdEnable, regionUpdateEnables}, 16'h0000);
    protWrite(1'b1, 3'h1);
    chk("rcOscRun", rcOscRun, 16'h0001);
    protWrite(1'b0, 3'h7);
    chk("updEnables", regionUpdateEnables, 16'h0007);
    foreach (rows[i]) begin
      runOp(rows[i], 0, hl);
      chk("failFlag", failFlag, rows[i].fail);
      if (rows[i].chkD) chk("flashDataByte", flashDataByte, rows[i].dout);
      if (!rows[i].fail) chk("holdCycles", hl, expHold(rows[i].ctrl));
    end
    codeRead(16'h0201, 8'h55);
    codeRead(16'h0202, 8'hFF);
    protWrite(1'b0, 3'h0);
    runOp('{8'h21, 16'h0201, 8'hAA, 8'h00, 1'b0, 1'b0}, 0, hl);
    chk("refusedFail", failFlag, 16'h0001);
    runOp(rows[9], 0, hl);
    chk("refusedKeeps", flashDataByte, 16'h0055);
    runOp(rows[0], 6, hl);
    chk("staleWindow", hl, 16'h0000);
    protWrite(1'b1, 3'h0);
    chk("rcOscStop", {flashCmdEnable, rcOscRun}, 16'h0000);
    runOp(rows[0], 0, hl);
    chk("disabledTrig", {hl[7:0], failFlag}, 16'h0000);
    extClockSelect = 1'b0;
    @(negedge core_clk);
    chk("rcOscInternal", rcOscRun, 16'h0001);
    summarize();
  end
endmodule
